// ### rtl/dpll_reference_switch_ctrl.sv
// Operation
// - manual modes take input from select pins
// - manual switch in Normal is hitless
// - outside lock window drops lock, full requalify
// - automatic picks only primary or secondary
// - failed input switches; both failed holds over
// - primary preferred after reset or sync-pair
// - automatic drives select pins, low shows input
// - both out-of-band holds over; Normal ignores
// - coarse failure gives holdover and input-failed
// - coarse failure past one second drops lock
// - past 2.5 seconds switches input, requalifies
// - clears under one second, keeps lock, input
// - clears before 2.5 seconds, requalifies lock
// - drift asserts input-failed on out-of-band
// - drift pulses holdover and switches input
// - mode pins pick Normal, Holdover, Freerun, Auto
// - any input change passes through TIE correction
`timescale 1ns/1ps
`include "drs_defs.svh"

module dpll_reference_switch_ctrl #(
    parameter logic [`DRS_CNT_W-1:0] LOCK_DISQ_CYC = `DRS_LOCK_DISQ_MS * `DRS_CYC_PER_MS,
    parameter logic [`DRS_CNT_W-1:0] REF_DISQ_CYC  = `DRS_REF_DISQ_MS * `DRS_CYC_PER_MS,
    parameter logic [`DRS_CNT_W-1:0] LOCK_TIME_CYC = `DRS_LOCK_TIME_MS * `DRS_CYC_PER_MS
) (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       ce_i,
    input  wire logic [1:0] mode_sel_i,
    input  wire logic [1:0] ref_sel_i,
    input  wire logic [1:0] input_out_of_band_i,
    input  wire logic       input_disrupted_i,
    input  wire logic       in_window_i,
    input  wire logic       phase_keep_on_recovery_i,
    output logic      [1:0] ref_sel_o,
    output logic            ref_sel_oe_o,
    output logic      [1:0] active_input_o,
    output logic      [3:0] loop_state_o,
    output logic            lock_o,
    output logic            holdover_o,
    output logic            input_failed_o
);

    // pin code to input in use; both high codes mean sync-pair
    function automatic logic [1:0] drs_decode(input logic [1:0] pins);
        if (pins[1]) begin
            drs_decode = drs_pkg::DRS_IN_SYNC_PAIR;
        end else begin
            drs_decode = pins;
        end
    endfunction : drs_decode

    // out-of-band flag of a primary or secondary input
    function automatic logic drs_oob(input logic [1:0] sel, input logic [1:0] oob);
        drs_oob = sel[0] ? oob[1] : oob[0];
    endfunction : drs_oob

    drs_timer_if ftmr ();
    drs_timer_if ltmr ();

    logic [1:0] sel_q;
    logic [1:0] next_sel;
    logic [3:0] loop_st;
    logic [3:0] next_loop;
    logic       pref;
    logic       next_pref;
    logic       force_tie;
    logic       next_force_tie;
    logic       sw_done;
    logic       next_sw_done;
    logic [7:0] ho_cnt;
    logic [7:0] next_ho_cnt;
    logic       lock;
    logic       next_lock;
    logic       auto_q;
    logic       ho_q;
    logic       next_ho;
    logic       failed_q;
    logic       next_failed;
    logic [1:0] ref_sel_q;
    logic [1:0] next_ref_sel;

    logic is_auto;
    logic tracking;
    logic cur_oob;
    logic oth_oob;
    logic coarse_sw;
    logic drift_sw;
    logic sel_change;
    logic lock_drop;

    // input selection: pins in manual modes, state machine in automatic
    always_comb begin
        is_auto      = (mode_sel_i == drs_pkg::DRS_MODE_AUTO);
        tracking     = (mode_sel_i == drs_pkg::DRS_MODE_NORMAL) || is_auto;
        cur_oob      = drs_oob(sel_q, input_out_of_band_i);
        oth_oob      = drs_oob(~sel_q, input_out_of_band_i);
        next_sel     = sel_q;
        next_pref    = pref;
        next_sw_done = sw_done && input_disrupted_i; // episode ends when input heals
        coarse_sw    = 1'b0;
        drift_sw     = 1'b0;
        if (!is_auto) begin
            next_sel  = drs_decode(ref_sel_i);
            next_pref = 1'b0;
        end else if (pref || sel_q == drs_pkg::DRS_IN_SYNC_PAIR) begin
            // first choice favours primary; never lands on sync-pair
            if (!input_out_of_band_i[0]) begin
                next_sel  = drs_pkg::DRS_IN_PRIMARY;
                next_pref = 1'b0;
            end else if (!input_out_of_band_i[1]) begin
                next_sel  = drs_pkg::DRS_IN_SECONDARY;
                next_pref = 1'b0;
            end else begin
                next_sel  = drs_pkg::DRS_IN_PRIMARY;
                next_pref = 1'b1;
            end
        end else if (!oth_oob && cur_oob) begin
            drift_sw = 1'b1;
            next_sel = {1'b0, ~sel_q[0]};
        end else if (!oth_oob && ftmr.hit_long && input_disrupted_i && !sw_done) begin
            coarse_sw    = 1'b1;
            next_sel     = {1'b0, ~sel_q[0]};
            next_sw_done = 1'b1;
        end
        sel_change = (next_sel != sel_q);
    end

    // failure-episode timer runs only while the input in use is disrupted
    assign ftmr.run     = is_auto && input_disrupted_i;
    assign ftmr.restart = !(is_auto && input_disrupted_i);

    drs_qual_timer #(
        .TC_SHORT (LOCK_DISQ_CYC),
        .TC_LONG  (REF_DISQ_CYC)
    ) u_fail_timer (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .tmr     (ftmr)
    );

    // loop state: holdover on any switch outside Freerun, recovery through TIE when asked
    always_comb begin
        next_loop      = loop_st;
        next_force_tie = force_tie || sel_change;
        next_ho_cnt    = (ho_cnt != 8'h00) ? ho_cnt - 8'h01 : 8'h00;
        if (drift_sw) begin
            next_ho_cnt = `DRS_HO_PULSE_CYC - 8'h01;
        end
        case (mode_sel_i)
            drs_pkg::DRS_MODE_HOLDOVER: begin
                next_loop = drs_pkg::DRS_LOOP_HOLDOVER;
            end
            drs_pkg::DRS_MODE_FREERUN: begin
                next_loop = drs_pkg::DRS_LOOP_FREERUN;
            end
            default: begin
                if (sel_change) begin
                    next_loop = drs_pkg::DRS_LOOP_HOLDOVER;
                end else if (input_disrupted_i) begin
                    next_loop = drs_pkg::DRS_LOOP_HOLDOVER;
                end else if (is_auto && (&input_out_of_band_i)) begin
                    next_loop = drs_pkg::DRS_LOOP_HOLDOVER;
                end else if (ho_cnt != 8'h00) begin
                    next_loop = drs_pkg::DRS_LOOP_HOLDOVER;
                end else if (loop_st == drs_pkg::DRS_LOOP_HOLDOVER
                             || loop_st == drs_pkg::DRS_LOOP_FREERUN) begin
                    // a changed input always keeps phase so the output sees no hit
                    if (force_tie || phase_keep_on_recovery_i) begin
                        next_loop = drs_pkg::DRS_LOOP_TIE_CORR;
                    end else begin
                        next_loop = drs_pkg::DRS_LOOP_NORMAL;
                    end
                end else begin
                    next_loop = drs_pkg::DRS_LOOP_NORMAL;
                end
            end
        endcase
        if (next_loop == drs_pkg::DRS_LOOP_NORMAL) begin
            next_force_tie = 1'b0;
        end
        next_ho = (next_loop == drs_pkg::DRS_LOOP_HOLDOVER);
    end

    // lock: dropped on window loss, long failure or coarse switch
    always_comb begin
        lock_drop = !tracking
                    || (loop_st == drs_pkg::DRS_LOOP_NORMAL && !in_window_i)
                    || (is_auto && input_disrupted_i && ftmr.hit_short)
                    || coarse_sw;
        if (lock_drop) begin
            next_lock = 1'b0;
        end else begin
            next_lock = lock || ltmr.hit_short;
        end
    end

    // requalify counts only in Normal, from zero after every drop
    assign ltmr.restart = lock_drop || (!lock && loop_st != drs_pkg::DRS_LOOP_NORMAL);
    assign ltmr.run     = (loop_st == drs_pkg::DRS_LOOP_NORMAL) && !lock;

    drs_qual_timer #(
        .TC_SHORT (LOCK_TIME_CYC),
        .TC_LONG  (LOCK_TIME_CYC)
    ) u_lock_timer (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .tmr     (ltmr)
    );

    // pin and flag outputs, computed ahead so they leave from flops
    always_comb begin
        next_failed  = is_auto && (input_disrupted_i || cur_oob);
        next_ref_sel = {1'b0, next_sel[0]};
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sel_q     <= drs_pkg::DRS_IN_PRIMARY;
            loop_st   <= drs_pkg::DRS_LOOP_HOLDOVER;
            pref      <= `DRS_RST_PREF;
            force_tie <= 1'b0;
            sw_done   <= 1'b0;
            ho_cnt    <= 8'h00;
            lock      <= `DRS_RST_LOCK;
            auto_q    <= 1'b0;
            ho_q      <= 1'b1;
            failed_q  <= 1'b0;
            ref_sel_q <= 2'h0;
        end else if (ce_i) begin
            sel_q     <= next_sel;
            loop_st   <= next_loop;
            pref      <= next_pref;
            force_tie <= next_force_tie;
            sw_done   <= next_sw_done;
            ho_cnt    <= next_ho_cnt;
            lock      <= next_lock;
            auto_q    <= is_auto;
            ho_q      <= next_ho;
            failed_q  <= next_failed;
            ref_sel_q <= next_ref_sel;
        end
    end

    assign ref_sel_o      = ref_sel_q;
    assign ref_sel_oe_o   = auto_q;
    assign active_input_o = sel_q;
    assign loop_state_o   = loop_st;
    assign lock_o         = lock;
    assign holdover_o     = ho_q;
    assign input_failed_o = failed_q;

    // checks, frozen together with the logic while the enable is low
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i || !ce_i);

    chk_manual_pin_select: assert property (
        (mode_sel_i != drs_pkg::DRS_MODE_AUTO) |=> (active_input_o == drs_decode($past(ref_sel_i)))
    ) else $error("manual selection does not follow pins");

    chk_auto_no_sync: assert property (
        auto_q |-> (active_input_o != drs_pkg::DRS_IN_SYNC_PAIR)
    ) else $error("automatic mode selected sync-pair input");

    chk_auto_pin_drive: assert property (
        ref_sel_oe_o |-> (ref_sel_o == {1'b0, active_input_o[0]})
    ) else $error("select pins do not show input in use");

    chk_both_oob_hold: assert property (
        (is_auto && (&input_out_of_band_i)) |=> holdover_o
    ) else $error("both inputs out of band without holdover");

    chk_coarse_hold_fail: assert property (
        (is_auto && input_disrupted_i) |=> (holdover_o && input_failed_o)
    ) else $error("coarse failure without holdover and input-failed");

    chk_lock_disq_time: assert property (
        (is_auto && input_disrupted_i && ftmr.hit_short) |=> !lock_o
    ) else $error("lock kept past lock-disqualify time");

    chk_window_drops_lock: assert property (
        (lock_o && loop_state_o == drs_pkg::DRS_LOOP_NORMAL && !in_window_i) |=> !lock_o
    ) else $error("lock kept outside phase-lock window");

    chk_switch_holdover: assert property (
        (tracking && sel_change) |=> (holdover_o ##1 (loop_state_o != drs_pkg::DRS_LOOP_NORMAL))
    ) else $error("input change did not pass through holdover and TIE");

    chk_drift_input_failed: assert property (
        (is_auto && cur_oob) |=> input_failed_o
    ) else $error("drift without input-failed");

    chk_auto_prefers_primary: assert property (
        (is_auto && (pref || active_input_o == drs_pkg::DRS_IN_SYNC_PAIR)
            && !input_out_of_band_i[0]) |=> (active_input_o == drs_pkg::DRS_IN_PRIMARY)
    ) else $error("primary not preferred in automatic");

    cov_coarse_switch: cover property (coarse_sw);
    cov_drift_switch: cover property (drift_sw ##1 holdover_o [*3]);
    cov_lock_gained: cover property (!lock_o ##1 lock_o);
    cov_both_oob: cover property (is_auto && (&input_out_of_band_i));

endmodule : dpll_reference_switch_ctrl

// ### rtl/drs_defs.svh
`ifndef DRS_DEFS_SVH
`define DRS_DEFS_SVH

// local master clock rate, 10 MHz
`define DRS_CLK_HZ          32'h0098_9680
// cycles in one millisecond
`define DRS_CYC_PER_MS      (`DRS_CLK_HZ / 32'h0000_03E8)
// lock-disqualify time, 1000 ms
`define DRS_LOCK_DISQ_MS    32'h0000_03E8
// reference-disqualify time, 2500 ms
`define DRS_REF_DISQ_MS     32'h0000_09C4
// lock-qualify time, 1000 ms by default
`define DRS_LOCK_TIME_MS    32'h0000_03E8
// holdover pulse on a drift switch, in clock cycles
`define DRS_HO_PULSE_CYC    8'h03
// counter width of the qualification timers
`define DRS_CNT_W           32
// saturation value of the timers
`define DRS_CNT_MAX         32'hFFFF_FFFF
// reset values
`define DRS_RST_PREF        1'b1
`define DRS_RST_LOCK        1'b0

`endif

// ### rtl/drs_pkg.sv
package drs_pkg;

    // mode select pin codes
    typedef enum logic [1:0] {
        DRS_MODE_NORMAL   = 2'h0,
        DRS_MODE_HOLDOVER = 2'h1,
        DRS_MODE_FREERUN  = 2'h2,
        DRS_MODE_AUTO     = 2'h3
    } drs_mode_e;

    // timing input in use
    typedef enum logic [1:0] {
        DRS_IN_PRIMARY   = 2'h0,
        DRS_IN_SECONDARY = 2'h1,
        DRS_IN_SYNC_PAIR = 2'h2
    } drs_input_e;

    // loop state, one-hot
    typedef enum logic [3:0] {
        DRS_LOOP_FREERUN  = 4'h1,
        DRS_LOOP_HOLDOVER = 4'h2,
        DRS_LOOP_TIE_CORR = 4'h4,
        DRS_LOOP_NORMAL   = 4'h8
    } drs_loop_e;

endpackage : drs_pkg

// ### rtl/drs_timer_if.sv
`timescale 1ns/1ps
`include "drs_defs.svh"

interface drs_timer_if;
    logic restart;
    logic run;
    logic hit_short;
    logic hit_long;

    // controller side starts and runs the timer
    modport ctrl (output restart, output run, input hit_short, input hit_long);
    // timer side reports terminal counts
    modport timer (input restart, input run, output hit_short, output hit_long);
endinterface : drs_timer_if

// ### rtl/drs_qual_timer.sv
`timescale 1ns/1ps
`include "drs_defs.svh"

module drs_qual_timer #(
    parameter logic [`DRS_CNT_W-1:0] TC_SHORT = `DRS_LOCK_DISQ_MS * `DRS_CYC_PER_MS,
    parameter logic [`DRS_CNT_W-1:0] TC_LONG  = `DRS_REF_DISQ_MS * `DRS_CYC_PER_MS
) (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        ce_i,
    drs_timer_if.timer       tmr
);

    logic [`DRS_CNT_W-1:0] cnt;
    logic [`DRS_CNT_W-1:0] next_cnt;

    // restart wins over counting; saturates so a long episode never wraps
    always_comb begin
        next_cnt = cnt;
        if (tmr.restart) begin
            next_cnt = '0;
        end else if (tmr.run && cnt != `DRS_CNT_MAX) begin
            next_cnt = cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cnt <= '0;
        end else if (ce_i) begin
            cnt <= next_cnt;
        end
    end

    // terminal counts reached
    assign tmr.hit_short = (cnt >= TC_SHORT);
    assign tmr.hit_long  = (cnt >= TC_LONG);

    chk_restart_clears_count: assert property (
        @(posedge clk_i) disable iff (!rst_b_i || !ce_i)
        tmr.restart |=> (cnt == '0)
    ) else $error("timer did not restart");

endmodule : drs_qual_timer

// ### verif/drs_ext_ctrl.sv
`timescale 1ns/1ps
// far-side controller model: owns the mode pins, shares the select pins
module drs_ext_ctrl (
    input  wire logic [1:0] want_mode_i,
    input  wire logic [1:0] want_sel_i,
    input  wire logic [1:0] dev_sel_i,
    input  wire logic       dev_oe_i,
    output logic      [1:0] mode_sel_o,
    output logic      [1:0] sel_pin_o
);
    // mode pins are always driven from this side
    assign mode_sel_o = want_mode_i;
    // controller lets go of the select pins while the device drives them,
    // so no contention is possible and only the device value is seen
    assign sel_pin_o = dev_oe_i ? dev_sel_i : want_sel_i;
endmodule : drs_ext_ctrl

// ### verif/dpll_reference_switch_ctrl_tb.sv
`timescale 1ns/1ps
module dpll_reference_switch_ctrl_tb;
    logic       clk_i;
    logic       rst_b_i;
    logic       ce_i;
    logic       disr;
    logic       in_win;
    logic       keep;
    logic [1:0] mode;
    logic [1:0] sel;
    logic [1:0] oob;
    logic [1:0] mode_pin;
    logic [1:0] sel_pin;
    logic [1:0] sel_o;
    logic [1:0] act;
    logic [1:0] cur;
    logic       sel_oe;
    logic       lock;
    logic       ho;
    logic       failed;
    logic [3:0] loop;
    int         n_errors;
    int         comparisons;
    int         n;

    // short timers: 20 / 50 / 30 cycles keep the run brief
    dpll_reference_switch_ctrl #(
        .LOCK_DISQ_CYC(32'h0000_0014),
        .REF_DISQ_CYC (32'h0000_0032),
        .LOCK_TIME_CYC(32'h0000_001E)
    ) u_dpll_reference_switch_ctrl (
        .clk_i                   (clk_i),
        .rst_b_i                 (rst_b_i),
        .ce_i                    (ce_i),
        .mode_sel_i              (mode_pin),
        .ref_sel_i               (sel_pin),
        .input_out_of_band_i     (oob),
        .input_disrupted_i       (disr),
        .in_window_i             (in_win),
        .phase_keep_on_recovery_i(keep),
        .ref_sel_o               (sel_o),
        .ref_sel_oe_o            (sel_oe),
        .active_input_o          (act),
        .loop_state_o            (loop),
        .lock_o                  (lock),
        .holdover_o              (ho),
        .input_failed_o          (failed)
    );

    drs_ext_ctrl u_drs_ext_ctrl (
        .want_mode_i(mode),
        .want_sel_i (sel),
        .dev_sel_i  (sel_o),
        .dev_oe_i   (sel_oe),
        .mode_sel_o (mode_pin),
        .sel_pin_o  (sel_pin)
    );

    // input in use expected for a select pin code
    function automatic logic [1:0] exp_in(input logic [1:0] s);
        return s[1] ? 2'(drs_pkg::DRS_IN_SYNC_PAIR) : {1'b0, s[0]};
    endfunction : exp_in

    task automatic report_and_stop;
        if (n_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    // inputs move only at falling edges
    task automatic step(input int k);
        repeat (k) @(negedge clk_i);
    endtask : step

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // bounded wait for lock; a run-out is a mismatch
    task automatic wait_lock;
        for (n = 0; n < 300 && lock !== 1'b1; n++) begin
            step(1);
        end
        chk(8'(lock), 8'h01, "lock gain");
        if (lock !== 1'b1) begin
            report_and_stop();
        end
    endtask : wait_lock

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // hang guard
    initial begin
        #6_000_000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        rst_b_i = 1'b0;
        ce_i = 1'b1;
        mode = 2'h0;
        sel = 2'h0;
        oob = 2'h0;
        disr = 1'b0;
        in_win = 1'b1;
        keep = 1'b0;
        n_errors = 0;
        comparisons = 0;
        void'($urandom(65));
        step(4);
        chk(8'(loop), 8'(drs_pkg::DRS_LOOP_HOLDOVER), "reset loop");
        chk(8'({ho, lock, sel_oe}), 8'h04, "reset flags");
        rst_b_i = 1'b1;
        wait_lock();
        // manual selects: every code, then random ones
        for (int i = 0; i < 10; i++) begin
            cur = act;
            sel = (i < 4) ? 2'(i) : 2'($urandom);
            keep = 1'($urandom);
            step(1);
            chk(8'(act), 8'(exp_in(sel)), "manual input");
            if (exp_in(sel) !== cur) begin
                chk(8'(loop), 8'(drs_pkg::DRS_LOOP_HOLDOVER), "switch via holdover");
            end
            step(3);
            chk(8'({loop[3], lock}), 8'h03, "hitless switch");
        end
        // frozen while the clock enable is low
        sel = 2'h0;
        step(4);
        ce_i = 1'b0;
        sel = 2'h1;
        step(3);
        chk(8'(act), 8'h00, "frozen");
        ce_i = 1'b1;
        step(4);
        chk(8'(act), 8'h01, "unfrozen");
        // leaving the lock window drops lock for the full lock time
        in_win = 1'b0;
        step(2);
        chk(8'(lock), 8'h00, "window loss");
        in_win = 1'b1;
        step(20);
        chk(8'(lock), 8'h00, "requalify");
        wait_lock();
        // out-of-band is ignored in manual Normal
        oob = 2'h3;
        step(3);
        chk(8'(loop), 8'(drs_pkg::DRS_LOOP_NORMAL), "oob ignored");
        oob = 2'h0;
        mode = 2'h1;
        step(2);
        chk(8'({loop, lock}), 8'h04, "holdover mode");
        mode = 2'h2;
        step(2);
        chk(8'(loop), 8'(drs_pkg::DRS_LOOP_FREERUN), "freerun mode");
        mode = 2'h0;
        sel = 2'h2;
        wait_lock();
        // automatic from sync-pair prefers primary
        mode = 2'h3;
        step(2);
        chk(8'({act, sel_o}), 8'h00, "auto primary");
        chk(8'(sel_oe), 8'h01, "pins driven");
        wait_lock();
        // slow drift on primary
        oob = 2'h1;
        step(1);
        chk(8'({act, sel_o}), 8'h05, "drift switch");
        chk(8'({ho, failed}), 8'h03, "drift flags");
        step(2);
        chk(8'(ho), 8'h01, "pulse held");
        step(1);
        chk(8'({ho, lock}), 8'h01, "pulse end");
        oob = 2'h0;
        wait_lock();
        // coarse failure cleared early
        cur = act;
        disr = 1'b1;
        step(1);
        chk(8'({ho, failed}), 8'h03, "coarse flags");
        step(4);
        disr = 1'b0;
        step(1);
        chk(8'({ho, failed, lock}), 8'h01, "short clear");
        chk(8'(act), 8'(cur), "short same input");
        // coarse failure cleared between the two limits
        step(3);
        disr = 1'b1;
        step(30);
        chk(8'(lock), 8'h00, "lock disqualified");
        disr = 1'b0;
        step(2);
        chk(8'({ho, failed, act}), 8'(cur), "mid clear");
        step(20);
        chk(8'(lock), 8'h00, "full lock time");
        wait_lock();
        // coarse failure past the long limit switches over
        disr = 1'b1;
        for (n = 0; n < 100 && act === cur; n++) begin
            step(1);
        end
        chk(8'(n >= 40 && n <= 60), 8'h01, "long switch time");
        disr = 1'b0;
        step(3);
        chk(8'({ho, lock}), 8'h00, "long switch flags");
        chk(8'({act, sel_o}), 8'({1'b0, ~cur[0], 1'b0, ~cur[0]}), "new input shown");
        wait_lock();
        // both inputs out of band: holdover on the same input
        cur = act;
        oob = 2'h3;
        step(3);
        chk(8'({ho, act}), 8'({1'b1, cur}), "both out of band");
        oob = 2'h0;
        wait_lock();
        // drift to secondary; no way back once primary heals
        oob = 2'h1;
        step(5);
        chk(8'(act), 8'h01, "drift other input");
        oob = 2'h0;
        step(3);
        chk(8'({act, sel_o}), 8'h05, "non-revertive");
        // reset in mid-run while automatic: starts over on primary
        rst_b_i = 1'b0;
        step(2);
        chk(8'({act, sel_oe, ho, lock}), 8'h02, "mid reset flags");
        rst_b_i = 1'b1;
        step(1);
        chk(8'({act, sel_o, sel_oe}), 8'h01, "reset prefers primary");
        step(1);
        chk(8'({ho, lock}), 8'h00, "reset recovery");
        report_and_stop();
    end
endmodule : dpll_reference_switch_ctrl_tb
